// file: pkg/upc_pkg.sv
`default_nettype none
package upc_pkg;
	// ==================================================
	// Sizes
	localparam int UPC_NPIPE = 8;
	localparam int UPC_AW = 8;
	localparam int UPC_DW = 16;
	localparam int UPC_MPS_W = 11;
	localparam int UPC_FIRST_BULK_PIPE = 3;
	localparam int UPC_FIRST_INT_PIPE = 6;
	localparam int UPC_SETUP_WORD_W = 16;
	// ==================================================
	// Address decode: [7] setup area, [6:4] pipe, [3:2] reg
	localparam int UPC_A_SETUP_BIT = 7;
	localparam int UPC_A_PIPE_LSB = 4;
	localparam int UPC_A_REG_LSB = 2;
	localparam logic [1:0] UPC_REG_CFG = 2'h0;
	localparam logic [1:0] UPC_REG_MAXP = 2'h1;
	localparam logic [1:0] UPC_REG_BUF = 2'h2;
	localparam logic [1:0] UPC_REG_CTRL = 2'h3;
	// ==================================================
	// Field positions
	localparam int UPC_CFG_TYPE_LSB = 14;
	localparam int UPC_CFG_READY_EVENT_MODE = 10;
	localparam int UPC_CFG_DOUBLE_BUFFER_SELECT = 9;
	localparam int UPC_CFG_CONTINUOUS_MODE = 8;
	localparam int UPC_CFG_NAK_ON_TRANSFER_END = 7;
	localparam int UPC_CFG_DIR = 4;
	localparam int UPC_CFG_EP_LSB = 0;
	localparam int UPC_BUF_SIZE_LSB = 10;
	localparam int UPC_BUF_NUM_LSB = 0;
	localparam int UPC_CTL_PID_LSB = 0;
	localparam int UPC_CTL_CONTROL_STAGE_COMPLETE = 2;
	localparam int UPC_CTL_TMON = 6;
	localparam int UPC_CTL_TSET = 7;
	localparam int UPC_CTL_TCLR = 8;
	localparam int UPC_CTL_AUTO_DISCARD_MODE = 9;
	localparam int UPC_CTL_BUFFER_STATE_FLAG = 15;
	// ==================================================
	// Codes and limits
	localparam logic [1:0] UPC_TT_CTRL = 2'h0;
	localparam logic [1:0] UPC_TT_BULK = 2'h1;
	localparam logic [1:0] UPC_TT_INTR = 2'h2;
	localparam logic [1:0] UPC_TT_ISO = 2'h3;
	localparam logic [1:0] UPC_PID_NAK = 2'h0;
	localparam logic [1:0] UPC_PID_BUF = 2'h1;
	localparam logic [1:0] UPC_PID_STALL = 2'h2;
	localparam logic [10:0] UPC_MPS_ZERO = 11'h000;
	localparam logic [10:0] UPC_INT_MPS_MIN = 11'h001;
	localparam logic [10:0] UPC_INT_MPS_MAX = 11'h040;
	localparam logic [4:0] UPC_DCP_BSIZE = 5'h03;
	localparam logic [4:0] UPC_INT_BSIZE = 5'h00;
	localparam logic [7:0] UPC_DCP_BNUM = 8'h00;
	localparam logic [7:0] UPC_INT_BNUM_BASE = 8'h04;
	localparam logic [7:0] UPC_USER_BNUM_MIN = 8'h06;
	localparam logic [7:0] UPC_USER_BNUM_MAX = 8'h4F;
	// ==================================================
	// Enums and carriers
	typedef enum logic [1:0] {UPC_TK_IN, UPC_TK_OUT, UPC_TK_SETUP} upc_tok_kind_t;
	typedef enum logic [2:0] {
		UPC_RS_ACK, UPC_RS_NAK, UPC_RS_STALL, UPC_RS_BUF, UPC_RS_ZLP
	} upc_rsp_t;
	typedef struct packed {
		logic [UPC_AW-1:0] addr;
		logic [UPC_DW-1:0] wdata;
		logic we;
		logic re;
	} upc_bus_t;
	typedef struct packed {
		logic [2:0] pipe;
		logic setup_ok;
		logic ack;
		logic short_pkt;
		logic trn_end;
		logic oversize;
		logic seq_err;
		logic [63:0] setup_data;
	} upc_evt_t;
	typedef struct packed {
		logic valid;
		logic [2:0] pipe;
		upc_tok_kind_t kind;
	} upc_tok_t;
	typedef struct packed {
		logic valid;
		logic [2:0] pipe;
		upc_rsp_t rsp;
		logic store_ok;
		logic toggle;
	} upc_ans_t;
	typedef struct packed {
		logic [1:0] pid;
		logic toggle;
		logic wr_block;
		logic rdy_emp_block;
		logic not_ready_event_block;
	} upc_pstat_t;
	typedef struct packed {
		logic [1:0] ptype;
		logic ready_event_mode;
		logic double_buffer_select;
		logic continuous_mode;
		logic nak_on_transfer_end;
		logic dir;
		logic auto_discard_mode;
		logic [3:0] ep;
		logic [UPC_MPS_W-1:0] mps;
		logic [4:0] bsize;
		logic [7:0] bnum;
		logic [1:0] pid;
		logic tog;
	} upc_pipe_t;
endpackage
`default_nettype wire

// file: design/upc_pipe_ctrl.sv
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module upc_pipe_ctrl (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	// Register port
	input wire upc_pkg::upc_bus_t i_bus,
	output logic [upc_pkg::UPC_DW-1:0] o_rdata,
	// Buffer state from buffer memory logic
	input wire logic [upc_pkg::UPC_NPIPE-1:0] i_buf_state,
	// Link engine events and token queries
	input wire upc_pkg::upc_evt_t i_evt,
	input wire upc_pkg::upc_tok_t i_tok,
	output upc_pkg::upc_ans_t o_ans,
	// Per-pipe status
	output upc_pkg::upc_pstat_t [upc_pkg::UPC_NPIPE-1:0] o_pstat,
	output logic o_control_stage_complete
);

	// ==================================================
	// State
	typedef struct packed {
		upc_pkg::upc_pipe_t [upc_pkg::UPC_NPIPE-1:0] pipe;
		logic [63:0] setup;
		logic [upc_pkg::UPC_DW-1:0] rdata;
		upc_pkg::upc_ans_t ans;
		upc_pkg::upc_pstat_t [upc_pkg::UPC_NPIPE-1:0] pstat;
		logic control_stage_complete;
	} upc_state_t;

	// Forces the fixed settings of each pipe class
	// Illegal writes are clamped, not refused, so a stray
	// write still leaves the pipe in a legal class
	function automatic upc_pkg::upc_pipe_t fix_pipe(
		input upc_pkg::upc_pipe_t pi, input int p);
		upc_pkg::upc_pipe_t f;
		f = pi;
		if (p == 0) begin
			f.ptype = upc_pkg::UPC_TT_CTRL;
			f.ep = '0;
			f.bsize = upc_pkg::UPC_DCP_BSIZE;
			f.bnum = upc_pkg::UPC_DCP_BNUM;
			f.double_buffer_select = 1'b0;
			f.ready_event_mode = 1'b0;
			f.nak_on_transfer_end = 1'b0;
			f.auto_discard_mode = 1'b0;
		end else if (p >= upc_pkg::UPC_FIRST_INT_PIPE) begin
			f.ptype = upc_pkg::UPC_TT_INTR;
			f.bsize = upc_pkg::UPC_INT_BSIZE;
			f.bnum = upc_pkg::UPC_INT_BNUM_BASE +
				8'(p - upc_pkg::UPC_FIRST_INT_PIPE);
			f.double_buffer_select = 1'b0;
			f.ready_event_mode = 1'b0;
			f.continuous_mode = 1'b0;
			f.nak_on_transfer_end = 1'b0;
			if (f.mps < upc_pkg::UPC_INT_MPS_MIN) begin
				f.mps = upc_pkg::UPC_INT_MPS_MIN;
			end else if (f.mps > upc_pkg::UPC_INT_MPS_MAX) begin
				f.mps = upc_pkg::UPC_INT_MPS_MAX;
			end
		end else begin
			if (p >= upc_pkg::UPC_FIRST_BULK_PIPE ||
					f.ptype != upc_pkg::UPC_TT_ISO) begin
				f.ptype = upc_pkg::UPC_TT_BULK;
			end
			if (f.ptype == upc_pkg::UPC_TT_ISO) begin
				f.continuous_mode = 1'b0;
				f.nak_on_transfer_end = 1'b0;
			end
			// Overlap between pipes' areas is not caught here
			if (f.bnum < upc_pkg::UPC_USER_BNUM_MIN) begin
				f.bnum = upc_pkg::UPC_USER_BNUM_MIN;
			end else if (f.bnum > upc_pkg::UPC_USER_BNUM_MAX) begin
				f.bnum = upc_pkg::UPC_USER_BNUM_MAX;
			end
		end
		return f;
	endfunction

	function automatic logic is_bulk0(input upc_pkg::upc_pipe_t pi);
		return pi.ptype == upc_pkg::UPC_TT_BULK &&
			pi.mps == upc_pkg::UPC_MPS_ZERO;
	endfunction

	// ==================================================
	// Pipe status
	// Derived from settings, never cleared, so a zero-size
	// bulk pipe is already quiet in the first cycle out of reset
	function automatic upc_pkg::upc_pstat_t pipe_stat(
		input upc_pkg::upc_pipe_t pi);
		upc_pkg::upc_pstat_t s;
		s.pid = pi.pid;
		s.toggle = pi.tog;
		s.wr_block = is_bulk0(pi) && pi.dir;
		s.rdy_emp_block = is_bulk0(pi);
		s.not_ready_event_block = is_bulk0(pi) && pi.dir;
		return s;
	endfunction

	function automatic upc_state_t reset_state();
		upc_state_t s;
		s = '0;
		for (int p = 0; p < upc_pkg::UPC_NPIPE; p++) begin
			s.pipe[p] = fix_pipe(s.pipe[p], p);
			s.pstat[p] = pipe_stat(s.pipe[p]);
		end
		return s;
	endfunction

	localparam upc_state_t ST_RST = reset_state();

	// ==================================================
	// Register read
	function automatic logic [upc_pkg::UPC_DW-1:0] rd_pipe(
		input upc_pkg::upc_pipe_t pi, input logic [1:0] sel,
		input logic buffer_state_flag);
		logic [upc_pkg::UPC_DW-1:0] r;
		r = '0;
		unique case (sel)
			upc_pkg::UPC_REG_CFG: begin
				r[upc_pkg::UPC_CFG_TYPE_LSB +: 2] = pi.ptype;
				r[upc_pkg::UPC_CFG_READY_EVENT_MODE] = pi.ready_event_mode;
				r[upc_pkg::UPC_CFG_DOUBLE_BUFFER_SELECT] = pi.double_buffer_select;
				r[upc_pkg::UPC_CFG_CONTINUOUS_MODE] = pi.continuous_mode;
				r[upc_pkg::UPC_CFG_NAK_ON_TRANSFER_END] = pi.nak_on_transfer_end;
				r[upc_pkg::UPC_CFG_DIR] = pi.dir;
				r[upc_pkg::UPC_CFG_EP_LSB +: 4] = pi.ep;
			end
			upc_pkg::UPC_REG_MAXP: begin
				r[upc_pkg::UPC_MPS_W-1:0] = pi.mps;
			end
			upc_pkg::UPC_REG_BUF: begin
				r[upc_pkg::UPC_BUF_SIZE_LSB +: 5] = pi.bsize;
				r[upc_pkg::UPC_BUF_NUM_LSB +: 8] = pi.bnum;
			end
			upc_pkg::UPC_REG_CTRL: begin
				r[upc_pkg::UPC_CTL_PID_LSB +: 2] = pi.pid;
				r[upc_pkg::UPC_CTL_TMON] = pi.tog;
				r[upc_pkg::UPC_CTL_AUTO_DISCARD_MODE] = pi.auto_discard_mode;
				r[upc_pkg::UPC_CTL_BUFFER_STATE_FLAG] = buffer_state_flag;
			end
		endcase
		return r;
	endfunction

	// ==================================================
	// Register write
	function automatic upc_pkg::upc_pipe_t wr_pipe(
		input upc_pkg::upc_pipe_t pi, input logic [1:0] sel,
		input logic [upc_pkg::UPC_DW-1:0] w);
		upc_pkg::upc_pipe_t f;
		f = pi;
		unique case (sel)
			upc_pkg::UPC_REG_CFG: begin
				f.ptype = w[upc_pkg::UPC_CFG_TYPE_LSB +: 2];
				f.ready_event_mode = w[upc_pkg::UPC_CFG_READY_EVENT_MODE];
				f.double_buffer_select = w[upc_pkg::UPC_CFG_DOUBLE_BUFFER_SELECT];
				f.continuous_mode = w[upc_pkg::UPC_CFG_CONTINUOUS_MODE];
				f.nak_on_transfer_end = w[upc_pkg::UPC_CFG_NAK_ON_TRANSFER_END];
				f.dir = w[upc_pkg::UPC_CFG_DIR];
				f.ep = w[upc_pkg::UPC_CFG_EP_LSB +: 4];
			end
			upc_pkg::UPC_REG_MAXP: begin
				f.mps = w[upc_pkg::UPC_MPS_W-1:0];
			end
			upc_pkg::UPC_REG_BUF: begin
				f.bsize = w[upc_pkg::UPC_BUF_SIZE_LSB +: 5];
				f.bnum = w[upc_pkg::UPC_BUF_NUM_LSB +: 8];
			end
			upc_pkg::UPC_REG_CTRL: begin
				// Only software may pick the buffer-driven code
				f.pid = w[upc_pkg::UPC_CTL_PID_LSB +: 2];
				f.auto_discard_mode = w[upc_pkg::UPC_CTL_AUTO_DISCARD_MODE];
				if (w[upc_pkg::UPC_CTL_TCLR]) begin
					f.tog = 1'b0;
				end else if (w[upc_pkg::UPC_CTL_TSET] &&
						f.ptype != upc_pkg::UPC_TT_ISO) begin
					f.tog = 1'b1;
				end
			end
		endcase
		return f;
	endfunction

	// ==================================================
	// Token answer
	// Takes the settings held before the token's edge, so a
	// write in the same cycle never splits one transaction
	function automatic upc_pkg::upc_ans_t answer_token(
		input upc_pkg::upc_pipe_t pi, input upc_pkg::upc_tok_t tk);
		upc_pkg::upc_ans_t a;
		a = '0;
		a.valid = 1'b1;
		a.pipe = tk.pipe;
		a.toggle = pi.tog;
		if (tk.kind == upc_pkg::UPC_TK_SETUP) begin
			a.rsp = upc_pkg::UPC_RS_ACK;
			a.store_ok = 1'b1;
		end else if (pi.pid[1]) begin
			a.rsp = upc_pkg::UPC_RS_STALL;
		end else if (pi.pid == upc_pkg::UPC_PID_NAK) begin
			a.rsp = upc_pkg::UPC_RS_NAK;
		end else if (is_bulk0(pi)) begin
			// Zero-size pipe never touches the buffer
			if (tk.kind == upc_pkg::UPC_TK_IN) begin
				a.rsp = upc_pkg::UPC_RS_ZLP;
			end else begin
				a.rsp = upc_pkg::UPC_RS_NAK;
			end
		end else begin
			a.rsp = upc_pkg::UPC_RS_BUF;
			a.store_ok = tk.kind == upc_pkg::UPC_TK_OUT;
		end
		return a;
	endfunction

	// ==================================================
	// Next state
	upc_state_t st_q;
	upc_state_t st_d;
	logic [2:0] bus_pipe;
	logic [1:0] bus_reg;
	logic bus_setup;
	logic [1:0] setup_idx;
	upc_pkg::upc_pipe_t tp;
	upc_pkg::upc_pipe_t ep;

	assign bus_pipe = i_bus.addr[upc_pkg::UPC_A_PIPE_LSB +: 3];
	assign bus_reg = i_bus.addr[upc_pkg::UPC_A_REG_LSB +: 2];
	assign bus_setup = i_bus.addr[upc_pkg::UPC_A_SETUP_BIT];
	assign setup_idx = i_bus.addr[upc_pkg::UPC_A_REG_LSB +: 2];
	assign tp = st_q.pipe[i_tok.pipe];

	always_comb begin
		st_d = st_q;
		st_d.rdata = '0;
		st_d.control_stage_complete = 1'b0;
		st_d.ans = '0;
		ep = '0;

		// Read data stands for one cycle only
		if (i_bus.re) begin
			if (bus_setup) begin
				if (bus_pipe == '0) begin
					st_d.rdata = st_q.setup[
						upc_pkg::UPC_SETUP_WORD_W*setup_idx +:
						upc_pkg::UPC_SETUP_WORD_W];
				end
			end else begin
				st_d.rdata = rd_pipe(st_q.pipe[bus_pipe], bus_reg,
					i_buf_state[bus_pipe]);
			end
		end

		// Software first, so link events below win a collision
		if (i_bus.we && !bus_setup) begin
			st_d.pipe[bus_pipe] = wr_pipe(st_q.pipe[bus_pipe], bus_reg,
				i_bus.wdata);
			if (bus_reg == upc_pkg::UPC_REG_CTRL && bus_pipe == '0) begin
				st_d.control_stage_complete = i_bus.wdata[upc_pkg::UPC_CTL_CONTROL_STAGE_COMPLETE];
			end
		end

		// Link events; device writes only NAK or STALL
		ep = st_d.pipe[i_evt.pipe];
		if (i_evt.ack) begin
			ep.tog = ~ep.tog;
		end
		if ((i_evt.short_pkt || i_evt.trn_end) && ep.nak_on_transfer_end &&
				ep.ptype == upc_pkg::UPC_TT_BULK &&
				ep.pid == upc_pkg::UPC_PID_BUF) begin
			ep.pid = upc_pkg::UPC_PID_NAK;
		end
		if (i_evt.oversize && ep.mps != upc_pkg::UPC_MPS_ZERO) begin
			ep.pid = upc_pkg::UPC_PID_STALL;
		end
		if (i_evt.pipe == '0) begin
			if (i_evt.setup_ok) begin
				ep.pid = upc_pkg::UPC_PID_NAK;
				// Data stage after SETUP starts at DATA1
				ep.tog = 1'b1;
				st_d.setup = i_evt.setup_data;
			end
			if (i_evt.seq_err) begin
				ep.pid = upc_pkg::UPC_PID_STALL;
			end
		end
		st_d.pipe[i_evt.pipe] = ep;

		for (int p = 0; p < upc_pkg::UPC_NPIPE; p++) begin
			st_d.pipe[p] = fix_pipe(st_d.pipe[p], p);
			st_d.pstat[p] = pipe_stat(st_d.pipe[p]);
		end

		if (i_tok.valid) begin
			st_d.ans = answer_token(tp, i_tok);
		end
	end

	// ==================================================
	// Registers
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_q <= ST_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign o_rdata = st_q.rdata;
	assign o_ans = st_q.ans;
	assign o_pstat = st_q.pstat;
	assign o_control_stage_complete = st_q.control_stage_complete;

endmodule // upc_pipe_ctrl
`default_nettype wire

// file: testbench/upc_checker.sv
`timescale 1ns/1ns
`default_nettype none
module upc_checker (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	// Watched ports
	input wire upc_pkg::upc_bus_t i_bus,
	input wire logic [upc_pkg::UPC_DW-1:0] o_rdata,
	input wire logic [upc_pkg::UPC_NPIPE-1:0] i_buf_state,
	input wire upc_pkg::upc_evt_t i_evt,
	input wire upc_pkg::upc_tok_t i_tok,
	input wire upc_pkg::upc_ans_t o_ans,
	input wire upc_pkg::upc_pstat_t [upc_pkg::UPC_NPIPE-1:0] o_pstat,
	input wire logic o_control_stage_complete
);
	default clocking dc @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	// ========================================
	// Token answers
	AST_ANS_PIPE:
		assert property (i_tok.valid |=> o_ans.valid
			&& o_ans.pipe == $past(i_tok.pipe)) else $error("answer pipe");
	AST_ANS_ONLY:
		assert property (o_ans.valid |-> $past(i_tok.valid))
			else $error("answer without token");
	AST_SETUP_ACK:
		assert property (i_tok.valid && i_tok.kind == upc_pkg::UPC_TK_SETUP
			|=> o_ans.rsp == upc_pkg::UPC_RS_ACK && o_ans.store_ok)
			else $error("setup not acked");
	AST_ZLP_IN:
		assert property (o_ans.valid && o_ans.rsp == upc_pkg::UPC_RS_ZLP
			|-> $past(i_tok.kind) == upc_pkg::UPC_TK_IN)
			else $error("zero length answer to non-IN");
	// ========================================
	// Device-written response and toggle
	AST_SETUP_NAK:
		assert property (i_evt.setup_ok && i_evt.pipe == 3'h0 && !i_evt.seq_err
			|=> o_pstat[0].pid == upc_pkg::UPC_PID_NAK && o_pstat[0].toggle)
			else $error("setup did not force NAK");
	AST_SEQ_STALL:
		assert property (i_evt.seq_err && i_evt.pipe == 3'h0
			|=> o_pstat[0].pid[1]) else $error("sequence error not stalled");
	AST_NO_SELF_BUF:
		assert property (o_pstat[1].pid == upc_pkg::UPC_PID_BUF
			&& $past(o_pstat[1].pid) != upc_pkg::UPC_PID_BUF
			|-> $past(i_bus.we) || $past(i_bus.we, 2))
			else $error("buffer response set without write");
	AST_TOG_FLIP:
		assert property (i_evt.ack && i_evt.pipe == 3'h2 && !i_bus.we
			|=> o_pstat[2].toggle != $past(o_pstat[2].toggle))
			else $error("toggle did not flip");
	AST_CONTROL_STAGE_COMPLETE:
		assert property (o_control_stage_complete |-> $past(i_bus.we)
			&& $past(i_bus.addr) == 8'h0C && $past(i_bus.wdata[2]))
			else $error("stray stage complete pulse");
	COV_SETUP: cover property (i_evt.setup_ok ##1 1'b1);
	COV_ZLP: cover property (o_ans.rsp == upc_pkg::UPC_RS_ZLP);
	COV_CONTROL_STAGE_COMPLETE: cover property (o_control_stage_complete);
endmodule // upc_checker
bind upc_pipe_ctrl upc_checker upc_checker_i (.i_core_clk(i_core_clk),
	.i_arst_n(i_arst_n), .i_bus(i_bus), .o_rdata(o_rdata),
	.i_buf_state(i_buf_state), .i_evt(i_evt), .i_tok(i_tok),
	.o_ans(o_ans), .o_pstat(o_pstat), .o_control_stage_complete(o_control_stage_complete));
`default_nettype wire

// file: testbench/upc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module upc_host_model (
	// Clock
	input wire logic i_core_clk,
	// Token and event strobes
	output var upc_pkg::upc_tok_t o_tok,
	output var upc_pkg::upc_evt_t o_evt
);
	initial begin
		o_tok = '0;
		o_evt = '0;
	end
	// ========================================
	// One-cycle strobes, dropped after one edge
	task automatic tok(input logic [2:0] p, input upc_pkg::upc_tok_kind_t k);
		o_tok <= '{valid: 1'b1, pipe: p, kind: k};
		@(posedge i_core_clk);
		o_tok <= '0;
		#1;
	endtask
	task automatic evt(input upc_pkg::upc_evt_t e);
		o_evt <= e;
		@(posedge i_core_clk);
		o_evt <= '0;
		#1;
	endtask
endmodule // upc_host_model
`default_nettype wire

// file: testbench/usb_pipe_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module usb_pipe_control_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	upc_pkg::upc_bus_t bus = '0;
	logic [7:0] bst = 8'hA5;
	logic [15:0] rdata;
	upc_pkg::upc_tok_t tok;
	upc_pkg::upc_evt_t evt;
	upc_pkg::upc_ans_t ans;
	upc_pkg::upc_pstat_t [7:0] pst;
	logic control_stage_complete;
	int err_count = 0;
	int comparisons = 0;
	int cyc = 0;
	always #2 clk = ~clk;
	upc_pipe_ctrl upc_pipe_ctrl_i (.i_core_clk(clk), .i_arst_n(rst_n),
		.i_bus(bus), .o_rdata(rdata), .i_buf_state(bst), .i_evt(evt),
		.i_tok(tok), .o_ans(ans), .o_pstat(pst), .o_control_stage_complete(control_stage_complete));
	upc_host_model upc_host_model_i (.i_core_clk(clk), .o_tok(tok),
		.o_evt(evt));
	// ========================================
	// Access and compare helpers
	task chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [15:0] d);
		bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge clk);
		bus.we <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		bus <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
		@(posedge clk);
		bus.re <= 1'b0;
		#1;
		chk(rdata & m, e);
	endtask
	task tk(input logic [2:0] p, input upc_pkg::upc_tok_kind_t k,
		input logic s, input upc_pkg::upc_rsp_t r);
		upc_host_model_i.tok(p, k);
		chk({8'h00, ans.valid, ans.pipe, ans.store_ok, ans.rsp},
			{8'h00, 1'b1, p, s, r});
	endtask
	// Flags: 20 setup, 10 ack, 08 short, 04 count end, 02 oversize, 01 seq
	task ev(input logic [2:0] p, input logic [5:0] f);
		upc_host_model_i.evt({p, f, 64'h1122334455667788});
	endtask
	task idle;
		@(posedge clk);
		#1;
	endtask
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Tests take under a hundred cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			report_and_stop();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		chk(rdata, 16'h0000);
		chk({13'h0000, ans.valid, control_stage_complete, pst[1].rdy_emp_block},
			16'h0001);
		rst_n <= 1'b1;
		idle();
		wr(8'h08, 16'hFFFF);
		wr(8'h68, 16'h7C07);
		rd(8'h08, 16'hFFFF, 16'h0C00);
		rd(8'h68, 16'hFFFF, 16'h0004);
		rd(8'h78, 16'hFFFF, 16'h0005);
		wr(8'h18, 16'h1402);
		rd(8'h18, 16'hFFFF, 16'h1406);
		wr(8'h28, 16'h0050);
		rd(8'h28, 16'h00FF, 16'h004F);
		rd(8'h90, 16'hFFFF, 16'h0000);
		rd(8'h0C, 16'h8000, 16'h8000);
		rd(8'h1C, 16'h8000, 16'h0000);
		wr(8'h64, 16'h0100);
		rd(8'h64, 16'h07FF, 16'h0040);
		wr(8'h74, 16'h0000);
		rd(8'h74, 16'h07FF, 16'h0001);
		// Response select on a bulk OUT pipe
		wr(8'h30, 16'h4003);
		wr(8'h34, 16'h0200);
		tk(3'h3, upc_pkg::UPC_TK_OUT, 1'b0, upc_pkg::UPC_RS_NAK);
		wr(8'h3C, 16'h0002);
		tk(3'h3, upc_pkg::UPC_TK_OUT, 1'b0, upc_pkg::UPC_RS_STALL);
		wr(8'h3C, 16'h0001);
		tk(3'h3, upc_pkg::UPC_TK_OUT, 1'b1, upc_pkg::UPC_RS_BUF);
		ev(3'h3, 6'h02);
		chk({15'h0000, pst[3].pid[1]}, 16'h0001);
		// Zero packet size bulk, IN then OUT
		wr(8'h40, 16'h4014);
		wr(8'h44, 16'h0000);
		wr(8'h4C, 16'h0001);
		tk(3'h4, upc_pkg::UPC_TK_IN, 1'b0, upc_pkg::UPC_RS_ZLP);
		chk({13'h0000, pst[4].wr_block, pst[4].rdy_emp_block,
			pst[4].not_ready_event_block}, 16'h0007);
		wr(8'h4C, 16'h0000);
		wr(8'h40, 16'h4004);
		wr(8'h4C, 16'h0001);
		tk(3'h4, upc_pkg::UPC_TK_OUT, 1'b0, upc_pkg::UPC_RS_NAK);
		chk({14'h0000, pst[4].rdy_emp_block, pst[4].not_ready_event_block},
			16'h0002);
		// Transfer end forces NAK until software restores it
		wr(8'h50, 16'h4185);
		rd(8'h50, 16'h0180, 16'h0180);
		wr(8'h54, 16'h0200);
		wr(8'h5C, 16'h0001);
		ev(3'h5, 6'h08);
		chk({14'h0000, pst[5].pid}, 16'h0000);
		tk(3'h5, upc_pkg::UPC_TK_OUT, 1'b0, upc_pkg::UPC_RS_NAK);
		wr(8'h5C, 16'h0001);
		ev(3'h5, 6'h04);
		chk({14'h0000, pst[5].pid}, 16'h0000);
		// Setup on the control pipe, then a sequence error
		wr(8'h04, 16'h0040);
		rd(8'h04, 16'h07FF, 16'h0040);
		wr(8'h0C, 16'h0001);
		tk(3'h0, upc_pkg::UPC_TK_SETUP, 1'b1, upc_pkg::UPC_RS_ACK);
		ev(3'h0, 6'h20);
		chk({13'h0000, pst[0].pid, pst[0].toggle}, 16'h0001);
		rd(8'h80, 16'hFFFF, 16'h7788);
		rd(8'h84, 16'hFFFF, 16'h5566);
		rd(8'h88, 16'hFFFF, 16'h3344);
		rd(8'h8C, 16'hFFFF, 16'h1122);
		ev(3'h0, 6'h01);
		chk({15'h0000, pst[0].pid[1]}, 16'h0001);
		wr(8'h0C, 16'h0004);
		chk({15'h0000, control_stage_complete}, 16'h0001);
		// Toggle flips, set, clear; set ignored on iso
		wr(8'h20, 16'h4002);
		chk({15'h0000, control_stage_complete}, 16'h0000);
		idle();
		ev(3'h2, 6'h10);
		chk({15'h0000, pst[2].toggle}, 16'h0001);
		ev(3'h2, 6'h10);
		chk({15'h0000, pst[2].toggle}, 16'h0000);
		wr(8'h2C, 16'h0080);
		idle();
		chk({15'h0000, pst[2].toggle}, 16'h0001);
		rd(8'h2C, 16'h0040, 16'h0040);
		upc_host_model_i.tok(3'h2, upc_pkg::UPC_TK_IN);
		chk({15'h0000, ans.toggle}, 16'h0001);
		wr(8'h2C, 16'h0100);
		idle();
		chk({15'h0000, pst[2].toggle}, 16'h0000);
		wr(8'h10, 16'hC001);
		wr(8'h14, 16'h0010);
		wr(8'h1C, 16'h0080);
		idle();
		chk({15'h0000, pst[1].toggle}, 16'h0000);
		wr(8'h1C, 16'h0001);
		tk(3'h1, upc_pkg::UPC_TK_OUT, 1'b1, upc_pkg::UPC_RS_BUF);
		report_and_stop();
	end
endmodule // usb_pipe_control_tb_top
`default_nettype wire
